// File: sd_cfg_pkg.sv
// Package: register map, field layout, reset values and threshold tables for the signal-detect bank
// Contract
// - Assert field decodes 50/40/75/58 mV
// - De-assert field decodes 37/22/55/45 mV
// - Thresholds apply only when override bit set
// - Thresholds affect only status indication switching
// - Force-off bit holds channel B detect inactive
// - Force-on bit holds channel B detect active while force-off is clear
package sd_cfg_pkg;

	// ==========================================================
	// Register indices: the byte address of a register is four times its index
	localparam logic [7:0] cha_thresh_off = 8'h12;
	localparam logic [7:0] spare_off = 8'h13;
	localparam logic [7:0] chb_override_off = 8'h14;
	localparam logic [7:0] gen_ctrl_off = 8'h08;

	// ==========================================================
	// Field positions and reset values
	localparam int assert_lsb = 2;
	localparam int deassert_lsb = 0;
	localparam int force_off_bit = 2;
	localparam int force_on_bit = 1;
	localparam int th_override_bit = 6;
	localparam logic [7:0] cha_thresh_rst = 8'h00;
	localparam logic [7:0] spare_rst = 8'h00;
	localparam logic [7:0] chb_override_rst = 8'h00;
	localparam logic [7:0] gen_ctrl_rst = 8'h00;
	localparam logic [7:0] cha_thresh_wmask = 8'h0f;
	localparam logic [7:0] chb_override_wmask = 8'h06;
	localparam logic [7:0] gen_ctrl_wmask = 8'h40;

	// ==========================================================
	// Threshold levels in mV, indexed by field code
	localparam logic [7:0] assert_mv_0 = 8'h32;
	localparam logic [7:0] assert_mv_1 = 8'h28;
	localparam logic [7:0] assert_mv_2 = 8'h4b;
	localparam logic [7:0] assert_mv_3 = 8'h3a;
	localparam logic [7:0] deassert_mv_0 = 8'h25;
	localparam logic [7:0] deassert_mv_1 = 8'h16;
	localparam logic [7:0] deassert_mv_2 = 8'h37;
	localparam logic [7:0] deassert_mv_3 = 8'h2d;

	typedef struct packed {
		logic [7:0] assert_mv;
		logic [7:0] deassert_mv;
	} thresh_t;

	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
	} ahb_addr_t;

endpackage

// File: sd_thresh_decode.sv
// Threshold decode: maps field codes or pin selection to mV levels
`timescale 1ns/100ps
module sd_thresh_decode (
	input wire logic [1:0] assert_code,
	input wire logic [1:0] deassert_code,
	input wire logic use_regs,
	input wire logic threshold_select_pin,
	output sd_cfg_pkg::thresh_t thresh
);
	// ==========================================================
	// Decode
	always_comb begin
		logic [1:0] a;
		logic [1:0] d;
		a = 2'h0;
		d = 2'h0;
		if (use_regs) begin
			a = assert_code;
			d = deassert_code;
		end else if (threshold_select_pin) begin
			// Pin high picks the upper levels; the pin maps to code 2 in both fields, 75 and 55 mV
			a = 2'h2;
			d = 2'h2;
		end
		case (a)
			2'h0: thresh.assert_mv = sd_cfg_pkg::assert_mv_0;
			2'h1: thresh.assert_mv = sd_cfg_pkg::assert_mv_1;
			2'h2: thresh.assert_mv = sd_cfg_pkg::assert_mv_2;
			default: thresh.assert_mv = sd_cfg_pkg::assert_mv_3;
		endcase
		case (d)
			2'h0: thresh.deassert_mv = sd_cfg_pkg::deassert_mv_0;
			2'h1: thresh.deassert_mv = sd_cfg_pkg::deassert_mv_1;
			2'h2: thresh.deassert_mv = sd_cfg_pkg::deassert_mv_2;
			default: thresh.deassert_mv = sd_cfg_pkg::deassert_mv_3;
		endcase
	end
endmodule

// File: signal_detect_config_regs.sv
// Signal-detect configuration registers behind an AHB-Lite slave
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps
module signal_detect_config_regs (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic threshold_select_pin,
	input wire logic chb_detect_raw,
	output logic chb_signal_detect,
	output logic [7:0] assert_mv,
	output logic [7:0] deassert_mv
);
	// ==========================================================
	// Registers
	logic [7:0] gen_ctrl_q;
	logic [7:0] cha_thresh_q;
	logic [7:0] spare_q;
	logic [7:0] chb_override_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic pin_s1_q;
	logic pin_s2_q;
	logic raw_s1_q;
	logic raw_s2_q;
	sd_cfg_pkg::thresh_t thresh;
	logic [7:0] acc_idx;
	logic addr_ok;
	logic rd_take;
	logic wr_take;
	logic [7:0] rd_byte;

	// Register index of a byte address: each register owns one aligned word
	function automatic logic [7:0] word_off(input logic [31:0] a);
		word_off = a[9:2];
	endfunction

	// Only the lowest kilobyte holds registers; anything above is ignored and reads zero
	function automatic logic in_map(input logic [31:0] a);
		in_map = (a[31:10] == 22'h0);
	endfunction

	// Masked write value: bits outside the mask stay zero, so reserved bits read back zero
	function automatic logic [7:0] masked(input logic [31:0] wdata, input logic [7:0] mask);
		masked = wdata[7:0] & mask;
	endfunction

	// Data-phase write strobe for one register index
	function automatic logic wr_hit(input logic pend, input logic [7:0] idx, input logic [7:0] off);
		wr_hit = pend && (idx == off);
	endfunction

	// ==========================================================
	// Address phase
	// A request offered while clk_en is low is not taken although hreadyout stays high;
	// whoever freezes the bank must also hold the bus idle.
	// Transfer size is not checked: every register is one byte in the low lane of its word
	always_comb begin
		acc_idx = word_off(haddr);
		addr_ok = in_map(haddr);
		rd_take = hsel && hready && htrans[1] && !hwrite;
		wr_take = hsel && hready && htrans[1] && hwrite && addr_ok;
	end

	// Read value of the addressed register, zero where nothing is mapped
	always_comb begin
		rd_byte = 8'h00;
		if (!addr_ok) begin
			rd_byte = 8'h00;
		end else if (acc_idx == sd_cfg_pkg::gen_ctrl_off) begin
			rd_byte = gen_ctrl_q;
		end else if (acc_idx == sd_cfg_pkg::cha_thresh_off) begin
			rd_byte = cha_thresh_q;
		end else if (acc_idx == sd_cfg_pkg::spare_off) begin
			rd_byte = spare_q;
		end else if (acc_idx == sd_cfg_pkg::chb_override_off) begin
			rd_byte = chb_override_q;
		end
	end

	// ==========================================================
	// Bus slave: zero wait states, always OKAY
	// Every access completes in one cycle, so no wait state or error is ever signalled
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (clk_en) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Writes land in the data phase, when hwdata stands
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (clk_en) begin
			wr_pend_q <= wr_take;
			wr_addr_q <= acc_idx;
		end
	end

	// Read data registered in the address phase so it stands in the data phase
	// A read of an unmapped index returns zero with an OKAY response
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= 32'h00000000;
		end else if (clk_en && rd_take) begin
			hrdata <= {24'h000000, rd_byte};
		end
	end

	// ==========================================================
	// Register writes, one register to a process
	// General control: only the threshold override bit is kept
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			gen_ctrl_q <= sd_cfg_pkg::gen_ctrl_rst;
		end else if (clk_en && wr_hit(wr_pend_q, wr_addr_q, sd_cfg_pkg::gen_ctrl_off)) begin
			gen_ctrl_q <= masked(hwdata, sd_cfg_pkg::gen_ctrl_wmask);
		end
	end

	// Channel A thresholds: only the two code fields are kept
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cha_thresh_q <= sd_cfg_pkg::cha_thresh_rst;
		end else if (clk_en && wr_hit(wr_pend_q, wr_addr_q, sd_cfg_pkg::cha_thresh_off)) begin
			cha_thresh_q <= masked(hwdata, sd_cfg_pkg::cha_thresh_wmask);
		end
	end

	// Channel B override: force-off and force-on bits only
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			chb_override_q <= sd_cfg_pkg::chb_override_rst;
		end else if (clk_en && wr_hit(wr_pend_q, wr_addr_q, sd_cfg_pkg::chb_override_off)) begin
			chb_override_q <= masked(hwdata, sd_cfg_pkg::chb_override_wmask);
		end
	end

	// Reserved word: nothing is writable, so it always reads its reset value
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			spare_q <= sd_cfg_pkg::spare_rst;
		end else if (clk_en) begin
			spare_q <= sd_cfg_pkg::spare_rst;
		end
	end

	// ==========================================================
	// Pin synchronisers: both pins are asynchronous, two flops before any logic
	// A low pin after reset keeps the default levels until the first real sample
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else if (clk_en) begin
			pin_s1_q <= threshold_select_pin;
			pin_s2_q <= pin_s1_q;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			raw_s1_q <= 1'b0;
			raw_s2_q <= 1'b0;
		end else if (clk_en) begin
			raw_s1_q <= chb_detect_raw;
			raw_s2_q <= raw_s1_q;
		end
	end

	// ==========================================================
	// Threshold selection
	// Register codes win over the pin only while the override bit is set
	sd_thresh_decode u_decode (
		.assert_code(cha_thresh_q[sd_cfg_pkg::assert_lsb +: 2]),
		.deassert_code(cha_thresh_q[sd_cfg_pkg::deassert_lsb +: 2]),
		.use_regs(gen_ctrl_q[sd_cfg_pkg::th_override_bit]),
		.threshold_select_pin(pin_s2_q),
		.thresh(thresh)
	);

	// Levels go only to the detector comparator, never to the datapath
	// A code change reaches these outputs one edge after the register write lands
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			assert_mv <= sd_cfg_pkg::assert_mv_0;
			deassert_mv <= sd_cfg_pkg::deassert_mv_0;
		end else if (clk_en) begin
			assert_mv <= thresh.assert_mv;
			deassert_mv <= thresh.deassert_mv;
		end
	end

	// ==========================================================
	// Channel B override
	// Overrides act on the synchronised detector result, so with no override set the raw
	// result shows three edges after it changes; force-off wins over force-on
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			chb_signal_detect <= 1'b0;
		end else if (clk_en) begin
			if (chb_override_q[sd_cfg_pkg::force_off_bit]) begin
				chb_signal_detect <= 1'b0;
			end else if (chb_override_q[sd_cfg_pkg::force_on_bit]) begin
				chb_signal_detect <= 1'b1;
			end else begin
				chb_signal_detect <= raw_s2_q;
			end
		end
	end
endmodule

// File: sd_cfg_monitor.sv
// Checker of bus and output relations for the signal-detect bank
`timescale 1ns/100ps
module sd_cfg_monitor (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic chb_detect_raw,
	input wire logic chb_signal_detect,
	input wire logic [7:0] assert_mv,
	input wire logic [7:0] deassert_mv
);
	logic [4:0] wr_h;
	logic [4:0] raw_h;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// ==========================================
	// History of writes and raw detect, to excuse a detect edge; it steps only with clk_en
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_h <= 5'h00;
			raw_h <= 5'h00;
		end else if (clk_en) begin
			wr_h <= {wr_h[3:0], hsel && hready && htrans[1] && hwrite};
			raw_h <= {raw_h[3:0], chb_detect_raw};
		end
	end
	sequence no_rd;
		!(hsel && hready && htrans[1] && !hwrite);
	endsequence
	sequence frozen;
		!clk_en;
	endsequence
	okay_resp_a: assert property (hresp == 1'b0) else $error("error response seen");
	zero_wait_a: assert property (hreadyout == 1'b1) else $error("wait state seen");
	assert_legal_a: assert property (assert_mv inside {8'h32, 8'h28, 8'h4b, 8'h3a})
		else $error("assert level off table");
	deassert_legal_a: assert property (deassert_mv inside {8'h25, 8'h16, 8'h37, 8'h2d})
		else $error("deassert level off table");
	upper_zero_a: assert property (hrdata[31:8] == 24'h000000) else $error("upper read bits set");
	read_hold_a: assert property (no_rd |=> $stable(hrdata)) else $error("read data moved");
	freeze_hold_a: assert property (frozen |=> $stable(chb_signal_detect) && $stable(assert_mv) && $stable(deassert_mv)
		&& $stable(hrdata)) else $error("state moved while frozen");
	reset_vals_a: assert property ($rose(arst_n) |-> assert_mv == 8'h32 && deassert_mv == 8'h25)
		else $error("bad levels after reset");
	detect_cause_a: assert property ($rose(chb_signal_detect) |-> raw_h[3:1] != 3'b000 || wr_h[4:2] != 3'b000)
		else $error("detect rose without cause");
endmodule
bind signal_detect_config_regs sd_cfg_monitor i_mon (.ref_clk, .arst_n, .clk_en, .hsel, .htrans, .hwrite, .hready,
	.hrdata, .hreadyout, .hresp, .chb_detect_raw, .chb_signal_detect, .assert_mv, .deassert_mv);

// File: signal_detect_config_regs_tb.sv
// Self-checking bench for the signal-detect bank
`timescale 1ns/100ps
module signal_detect_config_regs_tb;
	localparam logic [7:0] a_gen = sd_cfg_pkg::gen_ctrl_off << 2;
	localparam logic [7:0] a_thr = sd_cfg_pkg::cha_thresh_off << 2;
	localparam logic [7:0] a_spr = sd_cfg_pkg::spare_off << 2;
	localparam logic [7:0] a_chb = sd_cfg_pkg::chb_override_off << 2;
	logic ref_clk = 1'b0;
	logic arst_n, ce, hsel, hwrite, pin, raw, hreadyout, hresp, det;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [7:0] amv, dmv;
	logic [31:0] rnd = 32'h000088df;
	int err_total = 0;
	int compares = 0;
	int i;
	int at[4] = '{50, 40, 75, 58};
	int dt[4] = '{37, 22, 55, 45};
	initial forever #12.5 ref_clk = ~ref_clk;
	signal_detect_config_regs i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .threshold_select_pin(pin), .chb_detect_raw(raw),
		.chb_signal_detect(det), .assert_mv(amv), .deassert_mv(dmv));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task results;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ==========================================
	// Bus master: waits on hready, never a fixed count
	task wt;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			results;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		wt;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		wt;
		r = hrdata;
	endtask
	task settle(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		{arst_n, hsel, hwrite, pin, raw, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		ce = 1'b1;
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		#1;
		chk(amv, 50);
		chk(dmv, 37);
		chk(det, 0);
		bus(1'b0, a_thr, 8'h00);
		chk(r, 0);
		bus(1'b0, a_chb, 8'h00);
		chk(r, 0);
		bus(1'b1, a_spr, 8'h00);
		bus(1'b0, a_spr, 8'h00);
		chk(r, 0);
		// Register values must stay ignored until the override bit is set
		pin <= 1'b1;
		bus(1'b1, a_thr, 8'h05);
		settle(4);
		chk(amv, 75);
		chk(dmv, 55);
		bus(1'b1, a_gen, 8'h40);
		for (i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			pin <= rnd[0];
			bus(1'b1, a_thr, 8'(i));
			settle(4);
			chk(amv, at[i / 4]);
			chk(dmv, dt[i % 4]);
			bus(1'b0, a_thr, 8'h00);
			chk(r, i);
		end
		// Reset in mid-run must bring general control, channel A thresholds and both levels back to their defaults
		pin <= 1'b0;
		arst_n <= 1'b0;
		settle(3);
		arst_n <= 1'b1;
		settle(4);
		chk(amv, 50);
		chk(dmv, 37);
		bus(1'b0, a_gen, 8'h00);
		chk(r, 0);
		bus(1'b0, a_thr, 8'h00);
		chk(r, 0);
		for (i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			raw <= rnd[0];
			bus(1'b1, a_chb, {5'h00, i[1:0], 1'b0});
			settle(4);
			chk(det, i[1] ? 0 : (i[0] ? 1 : rnd[0]));
		end
		// A frozen bank must ignore the detector until clk_en returns
		raw <= 1'b0;
		bus(1'b1, a_chb, 8'h00);
		settle(4);
		chk(det, 0);
		ce <= 1'b0;
		raw <= 1'b1;
		settle(6);
		chk(det, 0);
		ce <= 1'b1;
		settle(4);
		chk(det, 1);
		bus(1'b1, 8'hfc, 8'h5a);
		bus(1'b0, 8'hfc, 8'h00);
		chk(r, 0);
		results;
	end
endmodule
